// ==== mic_pkg.sv ====
// Shared constants and types of the maskable interrupt controller
package mic_pkg;
  // Source count and register map
  localparam int NUM_SRC = 44;
  localparam int IDX_W = 6;
  localparam int LVL_W = 3;
  localparam logic [15:0] CTRL_BASE = 16'hf100;
  localparam logic [15:0] CTRL_STRIDE = 16'h0002;
  localparam logic [15:0] IRQ_STAT_ADDR = 16'hf1a0;
  localparam logic [15:0] IRQ_MASK_ADDR = 16'hf1a2;
  // Source control register layout
  localparam int REQ_BIT = 7;
  localparam int MASK_BIT = 6;
  localparam int RSVD_MSB = 5;
  localparam int RSVD_LSB = 3;
  localparam logic [7:0] CTRL_WMASK = 8'hc7;
  localparam logic [7:0] CTRL_RST = 8'h47;
  // Status word layout
  localparam int SW_BLOCK_BIT = 5;
  localparam int SW_EXC_BIT = 6;
  localparam int SW_NMI_BIT = 7;
  localparam logic [7:0] SW_RST = 8'h20;
  // Exception code and handler address of source n: base plus n * 16
  localparam logic [15:0] EXC_BASE = 16'h0080;
  localparam int EXC_SHIFT = 4;
  // In-service tracking: one bit per level, level code 8 means none
  localparam int NUM_LVL = 8;
  localparam logic [3:0] LVL_NONE = 4'h8;
  // Event bits of the interrupt status register
  localparam int EV_W = 3;
  localparam int EV_ACK = 0;
  localparam int EV_RET = 1;
  localparam int EV_REFUSE = 2;
  localparam logic [7:0] IRQ_RST = 8'h00;
  // Acknowledge and return sequence steps
  typedef enum logic [2:0] {
    SEQ_IDLE = 3'b000,
    SEQ_SAVE_PC = 3'b001,
    SEQ_SAVE_SW = 3'b010,
    SEQ_CAUSE = 3'b011,
    SEQ_FLAGS = 3'b100,
    SEQ_JUMP = 3'b101,
    SEQ_RET_LOAD = 3'b110,
    SEQ_RET_JUMP = 3'b111
  } mic_seq_t;
endpackage

// ==== mic_arbiter.sv ====
// Combinational winner selection among pending unmasked requests
`timescale 1ns/1ns
`default_nettype none
module mic_arbiter #(
  parameter int NUM_SRC = mic_pkg::NUM_SRC
) (
  // Requests and their levels, three bits per source
  input wire logic [NUM_SRC-1:0] req,
  input wire logic [NUM_SRC*mic_pkg::LVL_W-1:0] lvl,
  // Winner
  output logic win_valid,
  output logic [mic_pkg::IDX_W-1:0] win_idx,
  output logic [mic_pkg::LVL_W-1:0] win_lvl
);
  // Linear scan: lower index wins ties, so it acts as the default order
  always_comb
  begin
    win_valid = 1'b0;
    win_idx = '0;
    win_lvl = '1;
    for (int i = 0; i < NUM_SRC; i++)
    begin
      // Code 0 is the best level; only a strictly better level displaces
      if (req[i] && (!win_valid || lvl[i*mic_pkg::LVL_W +: mic_pkg::LVL_W] < win_lvl))
      begin
        win_valid = 1'b1;
        win_idx = mic_pkg::IDX_W'(i);
        win_lvl = lvl[i*mic_pkg::LVL_W +: mic_pkg::LVL_W];
      end
    end
  end
endmodule
`default_nettype wire

// ==== mic_sequencer.sv ====
// Step sequencer for acknowledge and return processing
`timescale 1ns/1ns
`default_nettype none
module mic_sequencer (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Starts, only honoured in idle
  input wire logic start_ack,
  input wire logic start_ret,
  // Current step
  output mic_pkg::mic_seq_t step
);
  mic_pkg::mic_seq_t step_q, step_d;

  // One step per cycle, fixed order
  always_comb
  begin
    case (step_q)
      mic_pkg::SEQ_IDLE:
      begin
        if (start_ret)
          step_d = mic_pkg::SEQ_RET_LOAD;
        else if (start_ack)
          step_d = mic_pkg::SEQ_SAVE_PC;
        else
          step_d = mic_pkg::SEQ_IDLE;
      end
      mic_pkg::SEQ_SAVE_PC: step_d = mic_pkg::SEQ_SAVE_SW;
      mic_pkg::SEQ_SAVE_SW: step_d = mic_pkg::SEQ_CAUSE;
      mic_pkg::SEQ_CAUSE: step_d = mic_pkg::SEQ_FLAGS;
      mic_pkg::SEQ_FLAGS: step_d = mic_pkg::SEQ_JUMP;
      mic_pkg::SEQ_RET_LOAD: step_d = mic_pkg::SEQ_RET_JUMP;
      default: step_d = mic_pkg::SEQ_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge clk)
  begin
    if (rst)
      step_q <= mic_pkg::SEQ_IDLE;
    else
      step_q <= step_d;
  end

  assign step = step_q;
endmodule
`default_nettype wire

// ==== mic_top.sv ====
// Maskable interrupt controller with status word and entry/return logic
// Functional notes
// - There are 44 maskable sources, each with its own control register and request path.
// - The pending unmasked request with the best level wins, ties go to the lower index.
// - Bits 2 to 0 hold the level, code 0 is the highest and 7 the lowest.
// - Acknowledge sets the disable flag, blocking further maskable requests until cleared.
// - With interrupts enabled in a handler, only a strictly better level may preempt it.
// - Acknowledge saves PC and status, writes the cause, sets disable, clears exception, jumps.
// - A request waits while masked or while NMI-active or disable is set.
// - Return with exception and NMI-active flags clear reloads PC and status from saved copies.
// - Control registers take whole byte accesses or single-bit accesses.
// - Bit 7 is the request flag and hardware clears it on acknowledge.
// - Bit 6 is the mask flag; set, the request stays pending.
`timescale 1ns/1ns
`default_nettype none
module mic_top #(
  parameter int NUM_SRC = mic_pkg::NUM_SRC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic reg_bit_mode,
  input wire logic [2:0] reg_bit_sel,
  output logic [7:0] reg_rdata,
  // Source event pulses, peripherals and external pins
  input wire logic [NUM_SRC-1:0] src_event,
  // Core operations, one-cycle pulses
  input wire logic [31:0] cpu_ret_pc,
  input wire logic enable_interrupts_op,
  input wire logic mask_all_op,
  input wire logic return_from_interrupt_op,
  input wire logic load_system_reg_op,
  input wire logic [7:0] load_system_reg_data,
  // Core control outputs
  output logic pc_load,
  output logic [31:0] pc_target,
  output logic [7:0] processor_status_word,
  output logic [31:0] saved_return_pc,
  output logic [7:0] saved_status_word,
  output logic [15:0] maskable_cause_half,
  output logic busy,
  // Interrupt line
  output logic irq
);
  // Source control registers, one per source
  logic [7:0] ctrl_q [NUM_SRC];
  logic [7:0] ctrl_d [NUM_SRC];
  logic [NUM_SRC-1:0] pend;
  logic [NUM_SRC*mic_pkg::LVL_W-1:0] lvl_flat;
  logic win_valid;
  logic [mic_pkg::IDX_W-1:0] win_idx;
  logic [mic_pkg::LVL_W-1:0] win_lvl;
  mic_pkg::mic_seq_t step;
  logic take, start_ret, ops_ok, ret_refused;
  logic [mic_pkg::IDX_W-1:0] take_idx_q, take_idx_d;
  logic [mic_pkg::NUM_LVL-1:0] isr_q, isr_d;
  logic [7:0] sw_q, sw_d, spsw_q, spsw_d;
  logic [31:0] spc_q, spc_d, pc_q, pc_d;
  logic [15:0] cause_q, cause_d;
  logic [mic_pkg::EV_W-1:0] stat_q, stat_d, imask_q, imask_d, events;
  logic [7:0] rdata_q, rdata_d;
  logic wr_hit, rd_hit;
  logic [mic_pkg::IDX_W-1:0] wr_idx, rd_idx;

  // Address to source index, valid flag in the top bit
  function automatic logic [mic_pkg::IDX_W:0] ctrl_index(input logic [15:0] a);
    logic [15:0] off;
    off = a - mic_pkg::CTRL_BASE;
    if (a >= mic_pkg::CTRL_BASE && off[0] == 1'b0 && off[15:1] < 15'(NUM_SRC))
      ctrl_index = {1'b1, off[mic_pkg::IDX_W:1]};
    else
      ctrl_index = '0;
  endfunction

  // Best level currently in service, LVL_NONE when nothing runs
  function automatic logic [3:0] best_in_service(input logic [mic_pkg::NUM_LVL-1:0] v);
    best_in_service = mic_pkg::LVL_NONE;
    for (int l = mic_pkg::NUM_LVL - 1; l >= 0; l--)
      if (v[l])
        best_in_service = 4'(l);
  endfunction

  // Decode of the register port
  assign {wr_hit, wr_idx} = reg_wr ? ctrl_index(reg_addr) : '0;
  assign {rd_hit, rd_idx} = reg_rd ? ctrl_index(reg_addr) : '0;

  // Each source gets its own request path into the arbiter
  always_comb
  begin
    for (int i = 0; i < NUM_SRC; i++)
    begin
      pend[i] = ctrl_q[i][mic_pkg::REQ_BIT] && !ctrl_q[i][mic_pkg::MASK_BIT];
      lvl_flat[i*mic_pkg::LVL_W +: mic_pkg::LVL_W] = ctrl_q[i][mic_pkg::LVL_W-1:0];
    end
  end

  mic_arbiter #(.NUM_SRC(NUM_SRC)) u_arb (
    .req(pend),
    .lvl(lvl_flat),
    .win_valid(win_valid),
    .win_idx(win_idx),
    .win_lvl(win_lvl)
  );

  mic_sequencer u_seq (
    .clk(clk),
    .rst(rst),
    .start_ack(take),
    .start_ret(start_ret),
    .step(step)
  );

  // Take and return decisions; return beats a new acknowledge
  assign start_ret = (step == mic_pkg::SEQ_IDLE) && return_from_interrupt_op
    && !sw_q[mic_pkg::SW_EXC_BIT] && !sw_q[mic_pkg::SW_NMI_BIT];
  assign ret_refused = (step == mic_pkg::SEQ_IDLE) && return_from_interrupt_op && !start_ret;
  assign take = win_valid && (step == mic_pkg::SEQ_IDLE) && !return_from_interrupt_op
    && !sw_q[mic_pkg::SW_BLOCK_BIT] && !sw_q[mic_pkg::SW_NMI_BIT]
    && ({1'b0, win_lvl} < best_in_service(isr_q));
  assign ops_ok = (step == mic_pkg::SEQ_IDLE) && !take && !return_from_interrupt_op;

  // Control register next values; event set is applied last so it wins
  always_comb
  begin
    for (int i = 0; i < NUM_SRC; i++)
    begin
      ctrl_d[i] = ctrl_q[i];
      if (wr_hit && wr_idx == mic_pkg::IDX_W'(i))
      begin
        if (reg_bit_mode)
          ctrl_d[i][reg_bit_sel] = reg_wdata[0];
        else
          ctrl_d[i] = reg_wdata;
        ctrl_d[i] = ctrl_d[i] & mic_pkg::CTRL_WMASK;
      end
      if (take && win_idx == mic_pkg::IDX_W'(i))
        ctrl_d[i][mic_pkg::REQ_BIT] = 1'b0;
      if (src_event[i])
        ctrl_d[i][mic_pkg::REQ_BIT] = 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    for (int i = 0; i < NUM_SRC; i++)
      if (rst)
        ctrl_q[i] <= mic_pkg::CTRL_RST;
      else
        ctrl_q[i] <= ctrl_d[i];
  end

  // Entry and return processing, step by step
  always_comb
  begin
    sw_d = sw_q;
    spsw_d = spsw_q;
    spc_d = spc_q;
    pc_d = pc_q;
    cause_d = cause_q;
    isr_d = isr_q;
    take_idx_d = take ? win_idx : take_idx_q;
    if (take)
      isr_d[win_lvl] = 1'b1;
    case (step)
      mic_pkg::SEQ_SAVE_PC: spc_d = cpu_ret_pc;
      mic_pkg::SEQ_SAVE_SW: spsw_d = sw_q;
      mic_pkg::SEQ_CAUSE:
      begin
        cause_d = mic_pkg::EXC_BASE + (16'(take_idx_q) << mic_pkg::EXC_SHIFT);
        pc_d = {16'h0000, cause_d};
      end
      mic_pkg::SEQ_FLAGS:
      begin
        sw_d[mic_pkg::SW_BLOCK_BIT] = 1'b1;
        sw_d[mic_pkg::SW_EXC_BIT] = 1'b0;
      end
      mic_pkg::SEQ_RET_LOAD:
      begin
        sw_d = spsw_q;
        pc_d = spc_q;
        isr_d = isr_q & (isr_q - 8'h01); // Lowest set bit is the best level, no range hazard
      end
      default:
      begin
        // Core operations only act while no sequence is running
        if (ops_ok && enable_interrupts_op)
          sw_d[mic_pkg::SW_BLOCK_BIT] = 1'b0;
        else if (ops_ok && mask_all_op)
          sw_d[mic_pkg::SW_BLOCK_BIT] = 1'b1;
        else if (ops_ok && load_system_reg_op)
          sw_d = load_system_reg_data;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sw_q <= mic_pkg::SW_RST;
      spsw_q <= '0;
      spc_q <= '0;
      pc_q <= '0;
      cause_q <= '0;
      isr_q <= '0;
      take_idx_q <= '0;
    end
    else
    begin
      sw_q <= sw_d;
      spsw_q <= spsw_d;
      spc_q <= spc_d;
      pc_q <= pc_d;
      cause_q <= cause_d;
      isr_q <= isr_d;
      take_idx_q <= take_idx_d;
    end
  end

  // Interrupt status: events set, a written one clears, set wins
  assign events = {ret_refused, step == mic_pkg::SEQ_RET_JUMP, take};
  always_comb
  begin
    stat_d = stat_q;
    imask_d = imask_q;
    if (reg_wr && reg_addr == mic_pkg::IRQ_STAT_ADDR)
      stat_d = stat_q & ~reg_wdata[mic_pkg::EV_W-1:0];
    if (reg_wr && reg_addr == mic_pkg::IRQ_MASK_ADDR)
      imask_d = reg_wdata[mic_pkg::EV_W-1:0];
    stat_d = stat_d | events;
  end

  // Read data stands in the cycle after the strobe only
  always_comb
  begin
    rdata_d = 8'h00;
    if (rd_hit && reg_bit_mode)
      rdata_d = {7'h00, ctrl_q[rd_idx][reg_bit_sel]};
    else if (rd_hit)
      rdata_d = ctrl_q[rd_idx];
    else if (reg_rd && reg_addr == mic_pkg::IRQ_STAT_ADDR)
      rdata_d = {5'h00, stat_q};
    else if (reg_rd && reg_addr == mic_pkg::IRQ_MASK_ADDR)
      rdata_d = {5'h00, imask_q};
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      stat_q <= mic_pkg::IRQ_RST[mic_pkg::EV_W-1:0];
      imask_q <= mic_pkg::IRQ_RST[mic_pkg::EV_W-1:0];
      rdata_q <= '0;
    end
    else
    begin
      stat_q <= stat_d;
      imask_q <= imask_d;
      rdata_q <= rdata_d;
    end
  end

  // Outputs
  assign reg_rdata = rdata_q;
  assign irq = |(stat_q & imask_q);
  assign pc_load = (step == mic_pkg::SEQ_JUMP) || (step == mic_pkg::SEQ_RET_JUMP);
  assign pc_target = pc_q;
  assign processor_status_word = sw_q;
  assign saved_return_pc = spc_q;
  assign saved_status_word = spsw_q;
  assign maskable_cause_half = cause_q;
  assign busy = step != mic_pkg::SEQ_IDLE;

  // Helpers for checking: a better eligible source than the winner, reserved bits
  logic better_exists, rsvd_set;
  always_comb
  begin
    better_exists = 1'b0;
    rsvd_set = 1'b0;
    for (int i = 0; i < NUM_SRC; i++)
    begin
      if (pend[i] && (ctrl_q[i][2:0] < win_lvl
          || (ctrl_q[i][2:0] == win_lvl && mic_pkg::IDX_W'(i) < win_idx)))
        better_exists = 1'b1;
      if (ctrl_q[i][mic_pkg::RSVD_MSB:mic_pkg::RSVD_LSB] != 3'b000)
        rsvd_set = 1'b1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  best_pick_a: assert property (take |-> !better_exists)
    else $error("winner is not the best pending source");
  block_on_disable_a: assert property (sw_q[mic_pkg::SW_BLOCK_BIT] |-> !take)
    else $error("request taken while disabled");
  hold_pending_a: assert property (
    sw_q[mic_pkg::SW_NMI_BIT] || step != mic_pkg::SEQ_IDLE |-> !take)
    else $error("request taken while held");
  preempt_level_a: assert property (
    take |-> (isr_q & ((8'h02 << win_lvl) - 8'h01)) == 8'h00)
    else $error("preemption by a level that is not better");
  entry_order_a: assert property (take |=> step == mic_pkg::SEQ_SAVE_PC ##1
    spc_q == $past(cpu_ret_pc) ##1 spsw_q == $past(sw_q) ##2
    sw_q[mic_pkg::SW_BLOCK_BIT] && !sw_q[mic_pkg::SW_EXC_BIT] && pc_load)
    else $error("entry sequence out of order");
  return_restore_a: assert property (start_ret |=> ##1
    sw_q == $past(spsw_q, 2) && pc_target == $past(spc_q, 2) && pc_load)
    else $error("return did not restore saved state");
  masked_idle_a: assert property (take |-> ctrl_q[win_idx][mic_pkg::REQ_BIT]
    && !ctrl_q[win_idx][mic_pkg::MASK_BIT])
    else $error("masked or idle source taken");
  flag_clear_a: assert property (take && !src_event[win_idx]
    |=> !ctrl_q[$past(win_idx)][mic_pkg::REQ_BIT])
    else $error("request flag not cleared on acknowledge");
  event_sets_a: assert property (src_event[0] |=> ctrl_q[0][mic_pkg::REQ_BIT])
    else $error("event pulse lost");
  reserved_zero_a: assert property (!rsvd_set)
    else $error("reserved bits set");

  cover_take_c: cover property (take);
  cover_nested_c: cover property (take && isr_q != '0);
  cover_return_c: cover property (step == mic_pkg::SEQ_RET_JUMP);
endmodule
`default_nettype wire

// ==== mic_core_model.sv ====
// Core-side model: return PC source and jump follower
`timescale 1ns/1ns
`default_nettype none
module mic_core_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // From the controller
  input wire logic pc_load,
  input wire logic [31:0] pc_target,
  input wire logic busy,
  // To the controller and the bench
  output logic [31:0] cpu_ret_pc,
  output logic [31:0] exp_pc,
  output logic [31:0] last_target,
  output logic [31:0] n_loads
);
  logic busy_q;
  // Return PC moves every cycle, so a sample taken a cycle off shows
  always_ff @(posedge clk)
  begin
    busy_q <= busy;
    if (rst)
    begin
      cpu_ret_pc <= 32'h00001000;
      exp_pc <= 32'h00000000;
      last_target <= 32'h00000000;
      n_loads <= 32'h00000000;
    end
    else
    begin
      cpu_ret_pc <= cpu_ret_pc + 32'h00000004;
      if (busy && !busy_q)
        exp_pc <= cpu_ret_pc;
      if (pc_load)
      begin
        last_target <= pc_target;
        n_loads <= n_loads + 32'h00000001;
      end
    end
  end
endmodule
`default_nettype wire

// ==== tb_maskable_interrupt_controller.sv ====
// Self-checking bench of the maskable interrupt controller
`timescale 1ns/1ns
`default_nettype none
module tb_maskable_interrupt_controller;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [15:0] reg_addr = 16'h0000;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic reg_bit_mode = 1'b0;
  logic [2:0] reg_bit_sel = 3'h0;
  logic [mic_pkg::NUM_SRC-1:0] src_event = '0;
  logic en_op = 1'b0;
  logic dis_op = 1'b0;
  logic ret_op = 1'b0;
  logic ld_op = 1'b0;
  logic [7:0] ld_data = 8'h00;
  logic [7:0] reg_rdata;
  logic pc_load;
  logic [31:0] pc_target;
  logic [7:0] status_word;
  logic [31:0] saved_pc;
  logic [7:0] saved_sw;
  logic [15:0] cause;
  logic busy;
  logic irq;
  logic [31:0] cpu_ret_pc;
  logic [31:0] exp_pc;
  logic [31:0] last_target;
  logic [31:0] n_loads;
  logic [31:0] pc20;
  int n_errors = 0;
  int compares = 0;

  // Free-running clock, 8 ns period
  always #4 clk = ~clk;

  mic_top mic_top_inst (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_bit_mode(reg_bit_mode), .reg_bit_sel(reg_bit_sel),
    .reg_rdata(reg_rdata), .src_event(src_event), .cpu_ret_pc(cpu_ret_pc),
    .enable_interrupts_op(en_op), .mask_all_op(dis_op), .return_from_interrupt_op(ret_op),
    .load_system_reg_op(ld_op), .load_system_reg_data(ld_data), .pc_load(pc_load),
    .pc_target(pc_target), .processor_status_word(status_word), .saved_return_pc(saved_pc),
    .saved_status_word(saved_sw), .maskable_cause_half(cause), .busy(busy), .irq(irq));

  mic_core_model mic_core_model_inst (.clk(clk), .rst(rst), .pc_load(pc_load),
    .pc_target(pc_target), .busy(busy), .cpu_ret_pc(cpu_ret_pc), .exp_pc(exp_pc),
    .last_target(last_target), .n_loads(n_loads));

  // Address and cause of source n, worked out independently
  function automatic logic [15:0] ca(input int n);
    return mic_pkg::CTRL_BASE + 16'(n) * mic_pkg::CTRL_STRIDE;
  endfunction
  function automatic logic [15:0] ec(input int n);
    return mic_pkg::EXC_BASE + (16'(n) << mic_pkg::EXC_SHIFT);
  endfunction

  task print_verdict;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    compares++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("FAIL %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // Register port cycles, one strobe cycle each
  task wr(input logic [15:0] a, input logic [7:0] d, input logic bm, input logic [2:0] bs);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_bit_mode <= bm;
    reg_bit_sel <= bs;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_bit_mode <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 check(reg_rdata, e, "read data");
  endtask
  // Single-bit read; the data must drop back to zero one cycle later
  task rdb(input logic [15:0] a, input logic [2:0] bs, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_bit_mode <= 1'b1;
    reg_bit_sel <= bs;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 check(reg_rdata, e, "bit read");
    @(posedge clk);
    #1 check(reg_rdata, 8'h00, "read data stands one cycle");
  endtask

  // Core operation pulse: 0 enable, 1 disable, 2 return, 3 load status
  task op(input int k, input logic [7:0] d);
    @(posedge clk);
    en_op <= (k == 0);
    dis_op <= (k == 1);
    ret_op <= (k == 2);
    ld_op <= (k == 3);
    ld_data <= d;
    @(posedge clk);
    {en_op, dis_op, ret_op, ld_op} <= 4'h0;
  endtask

  task ev(input logic [mic_pkg::NUM_SRC-1:0] m);
    @(posedge clk);
    src_event <= m;
    @(posedge clk);
    src_event <= '0;
  endtask

  // A blocked request must not start a sequence
  task quiet(input int n);
    repeat (n)
    begin
      @(posedge clk);
      #1 check(busy, 1'b0, "unexpected take");
    end
  endtask

  // Bounded wait for the next jump seen by the core model
  task wait_load;
    logic [31:0] n0;
    n0 = n_loads;
    for (int i = 0; i < 40; i++)
    begin
      @(posedge clk);
      #1;
      if (n_loads !== n0)
        return;
    end
    check(32'h0, 32'h1, "no jump");
    print_verdict();
  endtask

  task take(input int n, input logic [7:0] sps);
    wait_load();
    check(pc_target, {16'h0000, ec(n)}, "handler");
    check(cause, ec(n), "cause");
    check(saved_pc, exp_pc, "saved pc");
    check(saved_sw, sps, "saved status");
    check(status_word, 8'h20, "status after take");
  endtask

  task t_reset;
    rd(ca(0), mic_pkg::CTRL_RST);
    rd(ca(43), mic_pkg::CTRL_RST);
    rd(16'hf1fe, 8'h00);
    rd(mic_pkg::IRQ_STAT_ADDR, 8'h00);
    check(status_word, 8'h20, "status reset");
  endtask

  task t_fields;
    wr(ca(5), 8'hff, 1'b0, 3'h0);
    rd(ca(5), 8'hc7);
    wr(ca(5), 8'h00, 1'b1, 3'h7);
    wr(ca(5), 8'h01, 1'b1, 3'h4);
    rd(ca(5), 8'h47);
  endtask

  // Levels, masking and the disable flag; sets up a tie checked in t_nest
  task t_prio;
    wr(ca(1), 8'h02, 1'b0, 3'h0);
    wr(ca(3), 8'h02, 1'b0, 3'h0);
    wr(ca(10), 8'h01, 1'b0, 3'h0);
    wr(ca(2), 8'h40, 1'b0, 3'h0);
    ev((44'h1 << 1) | (44'h1 << 2) | (44'h1 << 3) | (44'h1 << 10));
    quiet(10);
    rd(ca(2), 8'hc0);
    op(3, 8'h00);
    take(10, 8'h00);
    rd(ca(10), 8'h01);
    rd(ca(1), 8'h82);
  endtask

  // Preemption only by a strictly better level
  task t_nest;
    wr(ca(20), 8'h00, 1'b0, 3'h0);
    op(0, 8'h00);
    quiet(10);
    ev(44'h1 << 20);
    take(20, 8'h00);
    pc20 = exp_pc;
    op(2, 8'h00);
    wait_load();
    check(pc_target, pc20, "return pc");
    check(status_word, 8'h00, "return status");
    quiet(10);
    op(1, 8'h00);
    op(2, 8'h00);
    wait_load();
    take(1, 8'h00);
  endtask

  // Busy-by-NMI flag, refused return and the interrupt line
  task t_block;
    op(3, 8'h80);
    quiet(10);
    wr(ca(3), 8'h00, 1'b1, 3'h1);
    wr(ca(3), 8'h01, 1'b1, 3'h0);
    rd(ca(3), 8'h81);
    rdb(ca(3), 3'h7, 8'h01);
    op(2, 8'h00);
    rd(mic_pkg::IRQ_STAT_ADDR, 8'h07);
    wr(mic_pkg::IRQ_MASK_ADDR, 8'h04, 1'b0, 3'h0);
    #1 check(irq, 1'b1, "irq set");
    wr(mic_pkg::IRQ_STAT_ADDR, 8'h07, 1'b0, 3'h0);
    #1 check(irq, 1'b0, "irq cleared");
    op(3, 8'h00);
    take(3, 8'h00);
    wr(ca(2), 8'h00, 1'b1, 3'h6);
    quiet(5);
    op(3, 8'h20);
    op(2, 8'h00);
    wait_load();
    take(2, 8'h00);
    rd(ca(2), 8'h00);
  endtask

  // Main sequence
  initial
  begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_fields();
    t_prio();
    t_nest();
    t_block();
    print_verdict();
  end

  // Hang guard
  initial
  begin
    #400000;
    check(32'h0, 32'h1, "timeout");
    print_verdict();
  end
endmodule
`default_nettype wire
